//--- src/cas_pkg.sv
package cas_pkg;

  // register indices: byte offsets are all multiples of four, so the byte address is four times these
  localparam logic [7:0] IDX_THERMAL_AND_BATTERY_VOLTAGE = 8'h0E;
  localparam logic [7:0] IDX_SYSTEM_VOLTAGE_RESULT       = 8'h0F;
  localparam logic [7:0] IDX_INPUT_VOLTAGE_RESULT        = 8'h11;
  localparam logic [7:0] IDX_CHARGE_CURRENT_RESULT       = 8'h12;
  localparam logic [7:0] IDX_INPUT_LOOP_STATUS           = 8'h13;
  localparam logic [7:0] IDX_EVT_STATUS   = 8'h20;
  localparam logic [7:0] IDX_EVT_MASK     = 8'h21;
  localparam logic [7:0] IDX_CTRL         = 8'h22;

  localparam int ADDR_W      = 10;
  localparam int CODE_W      = 7;
  localparam int ILIM_W      = 6;
  localparam int EVT_W       = 4;

  // event bit positions
  localparam int EVT_THERM   = 0;
  localparam int EVT_INPUT   = 1;
  localparam int EVT_VLOOP   = 2;
  localparam int EVT_ILOOP   = 3;

  // control register bit positions
  localparam int CTRL_FREEZE = 0;

  localparam logic [6:0]  CODE_DEFAULT  = 7'h00;
  localparam logic [5:0]  ILIM_DEFAULT  = 6'h00;
  localparam logic [3:0]  MASK_RESET    = 4'h0;
  localparam logic [31:0] RDATA_UNMAPPED = 32'h00000000;

  // measurement frame presented by the converter and regulation loops
  typedef struct packed {
    logic       thermal_limit_flag;
    logic [6:0] battery_voltage_code;
    logic [6:0] system_voltage_code;
    logic       input_present_flag;
    logic [6:0] input_voltage_code;
    logic [6:0] charge_current_code;
    logic       battery_short;
    logic       input_voltage_loop_flag;
    logic       input_current_loop_flag;
    logic [5:0] applied_input_current_limit;
  } cas_meas_type;

endpackage

//--- src/cas_sync.sv
`timescale 1ns/1ps
module cas_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_r;

  initial begin
    if (WIDTH < 1) $error("cas_sync width must be positive");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_r <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      stage1_r <= async_in;
      sync_out <= stage1_r;
    end
  end

endmodule

//--- src/cas_sample.sv
`timescale 1ns/1ps
module cas_sample (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 clk_en,
  // conversion side
  input  wire logic                 conv_done,
  input  wire logic                 freeze,
  input  wire cas_pkg::cas_meas_type meas_in,
  // held result
  output cas_pkg::cas_meas_type     meas_held
);

  // results only move on a completed conversion, so reads never see a half-updated code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_held <= '0;
    end else if (clk_en && conv_done && !freeze) begin
      meas_held <= meas_in; // [R13]
      if (meas_in.battery_short)
        meas_held.charge_current_code <= cas_pkg::CODE_DEFAULT; // [R8]
    end
  end

endmodule

//--- src/cas_regs.sv
// Design decision made here: the APB register port.
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Bit 7 of the battery-voltage register reads 1 while thermal regulation limits charging.
// [R2] Bits 6..0 of that register give the battery voltage code, 20mV per lsb up to 1280mV msb.
// [R3] Bit 7 of the system-voltage register always reads 0.
// [R4] Bits 6..0 of the system-voltage register give the system voltage code, 20mV lsb to 1280mV msb.
// [R5] Bit 7 of the input-voltage register reads 1 while a good input supply is attached.
// [R6] The input-voltage code is 100mV per step over a 2.6V offset, 0 meaning 2.6V and the default.
// [R7] The charge-current code is 50mA per step from zero, defaulting to zero.
// [R8] The charge-current code reads all zeros while the battery sits below the short threshold.
// [R9] Bit 7 of the loop status register reads 1 while the input voltage loop regulates.
// [R10] Bit 6 of the loop status register reads 1 while the input current loop regulates.
// [R11] Bits 5..0 of the loop status register give the applied input current limit, 50mA to 1600mA.
// [R12] The five result registers are read-only and writes to them are ignored.
// [R13] Each result holds the last completed conversion stable between updates; while CTRL freeze is set, conversions are not taken.
module cas_regs (
  // apb
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      clk_en,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [cas_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // measurement inputs, asynchronous to pclk
  input  wire cas_pkg::cas_meas_type     meas_in,
  input  wire logic                      conv_done,
  // interrupt
  output logic                           irq
);

  cas_pkg::cas_meas_type meas_held;
  logic                  conv_done_s;
  logic                  conv_done_d_r;
  logic [cas_pkg::EVT_W-1:0] evt_status_r;
  logic [cas_pkg::EVT_W-1:0] evt_mask_r;
  logic                  freeze_r;
  logic [cas_pkg::EVT_W-1:0] flags_now;
  logic [cas_pkg::EVT_W-1:0] flags_prev_r;
  logic [cas_pkg::EVT_W-1:0] evt_set;
  logic [cas_pkg::EVT_W-1:0] evt_clr;
  logic                  setup;
  logic                  wr_acc;
  logic                  rd_acc;
  logic [7:0]            idx;
  logic                  word_ok;
  logic                  mapped;
  logic [31:0]           rd_nxt;
  logic                  conv_done_p;
  logic [2:0]            sync_prime_r;

  // the done strobe is a level toggle crossing, so synchronise then edge-detect
  cas_sync #(
    .WIDTH (1)
  ) u_done_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .async_in (conv_done),
    .sync_out (conv_done_s)
  );

  // a toggle level left over from before reset must not look like a fresh conversion;
  // edges are trusted once synchroniser and edge register agree with the pin, three edges on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_done_d_r <= 1'b0;
      sync_prime_r  <= 3'h0;
    end else if (clk_en) begin
      conv_done_d_r <= conv_done_s;
      sync_prime_r  <= {sync_prime_r[1:0], 1'b1};
    end
  end

  assign conv_done_p = sync_prime_r[2] && (conv_done_s ^ conv_done_d_r);

  // data bus is sampled only on the detected toggle edge, three cycles after the toggle moved, so it is settled
  cas_sample u_sample (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .conv_done (conv_done_p),
    .freeze    (freeze_r),
    .meas_in   (meas_in),
    .meas_held (meas_held)
  );

  // apb decode
  assign setup   = psel && !penable;
  assign idx     = paddr[cas_pkg::ADDR_W-1:2];
  assign word_ok = (paddr[1:0] == 2'h0);
  assign wr_acc  = setup && pwrite && clk_en;
  assign rd_acc  = setup && !pwrite && clk_en;

  always_comb begin
    mapped = 1'b1;
    rd_nxt = cas_pkg::RDATA_UNMAPPED;
    case (idx)
      cas_pkg::IDX_THERMAL_AND_BATTERY_VOLTAGE:
        rd_nxt[7:0] = {meas_held.thermal_limit_flag, meas_held.battery_voltage_code}; // [R1] [R2]
      cas_pkg::IDX_SYSTEM_VOLTAGE_RESULT:
        rd_nxt[7:0] = {1'b0, meas_held.system_voltage_code}; // [R3] [R4]
      cas_pkg::IDX_INPUT_VOLTAGE_RESULT:
        rd_nxt[7:0] = {meas_held.input_present_flag, meas_held.input_voltage_code}; // [R5] [R6]
      cas_pkg::IDX_CHARGE_CURRENT_RESULT:
        rd_nxt[7:0] = {1'b0, meas_held.charge_current_code}; // [R7]
      cas_pkg::IDX_INPUT_LOOP_STATUS:
        rd_nxt[7:0] = {meas_held.input_voltage_loop_flag, meas_held.input_current_loop_flag,
                       meas_held.applied_input_current_limit}; // [R9] [R10] [R11]
      cas_pkg::IDX_EVT_STATUS:
        rd_nxt[cas_pkg::EVT_W-1:0] = evt_status_r;
      cas_pkg::IDX_EVT_MASK:
        rd_nxt[cas_pkg::EVT_W-1:0] = evt_mask_r;
      cas_pkg::IDX_CTRL:
        rd_nxt[cas_pkg::CTRL_FREEZE] = freeze_r;
      default:
        mapped = 1'b0;
    endcase
    if (!word_ok) begin
      mapped = 1'b0;
      rd_nxt = cas_pkg::RDATA_UNMAPPED;
    end
  end

  // no wait state: answer is registered in the setup cycle, pready high in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (clk_en) begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (rd_acc)
        prdata <= rd_nxt;
      else if (setup)
        prdata <= '0;
    end
  end

  // writes to result registers fall through the decode untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_mask_r <= cas_pkg::MASK_RESET;
      freeze_r   <= 1'b0;
    end else if (wr_acc && word_ok && pstrb[0]) begin
      if (idx == cas_pkg::IDX_EVT_MASK)
        evt_mask_r <= pwdata[cas_pkg::EVT_W-1:0];
      if (idx == cas_pkg::IDX_CTRL)
        freeze_r <= pwdata[cas_pkg::CTRL_FREEZE];
    end
  end // [R12]

  // events: rising edges of the held status flags
  assign flags_now = {meas_held.input_current_loop_flag, meas_held.input_voltage_loop_flag,
                      meas_held.input_present_flag, meas_held.thermal_limit_flag};
  assign evt_set   = flags_now & ~flags_prev_r;
  assign evt_clr   = (wr_acc && word_ok && pstrb[0] && idx == cas_pkg::IDX_EVT_STATUS)
                     ? pwdata[cas_pkg::EVT_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_prev_r <= '0;
      evt_status_r <= '0;
    end else if (clk_en) begin
      flags_prev_r <= flags_now;
      // a new event wins over a simultaneous clear
      evt_status_r <= (evt_status_r & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq <= 1'b0;
    else if (clk_en)
      irq <= |(((evt_status_r & ~evt_clr) | evt_set) & evt_mask_r);
  end

endmodule

//--- test/cas_conv_model.sv
`timescale 1ns/1ps
module cas_conv_model (
  // clock
  input  wire logic                  pclk,
  // request from the bench
  input  wire logic                  go,
  input  wire cas_pkg::cas_meas_type frame,
  // converter side
  output cas_pkg::cas_meas_type      meas_in,
  output logic                       conv_done
);
  logic pend_r;
  initial begin
    meas_in = '0;
    conv_done = 1'b0;
    pend_r = 1'b0;
  end
  // frame settles a cycle before the toggle and then holds
  always @(posedge pclk) begin
    if (go) meas_in <= frame;
    pend_r <= go;
    if (pend_r) conv_done <= ~conv_done;
  end
endmodule

//--- test/cas_regs_checker.sv
`timescale 1ns/1ps
module cas_regs_checker (
  // clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // apb
  input wire logic                  pwrite,
  input wire logic [9:0]            paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // converter
  input wire cas_pkg::cas_meas_type meas_in,
  input wire logic                  conv_done
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0]            age_r;
  logic                  seen_r;
  logic                  done_q_r;
  cas_pkg::cas_meas_type meas_q_r;
  wire logic chg = (conv_done != done_q_r) || (meas_in != meas_q_r);
  wire logic rd_ok = pready && !pwrite && seen_r && (age_r == 3'h7);
  always_ff @(posedge pclk) begin
    done_q_r <= conv_done;
    meas_q_r <= meas_in;
  end
  // age of the frame; results are trusted only once it has settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_r <= 3'h0;
      seen_r <= 1'b0;
    end else begin
      age_r <= chg ? 3'h0 : (age_r == 3'h7 ? age_r : age_r + 3'h1);
      seen_r <= seen_r || (conv_done != done_q_r);
    end
  end
  AST_THERM_FLAG: assert property (rd_ok && paddr == 10'h038 |-> prdata[7] == meas_in.thermal_limit_flag)
    else $error("thermal flag mismatch");
  AST_BATT_CODE: assert property (rd_ok && paddr == 10'h038 |-> prdata[6:0] == meas_in.battery_voltage_code)
    else $error("battery code mismatch");
  AST_SYS_RSVD: assert property (pready && !pwrite && paddr == 10'h03C |-> prdata[31:7] == 25'h0)
    else $error("system reserved bit set");
  AST_SYS_CODE: assert property (rd_ok && paddr == 10'h03C |-> prdata[6:0] == meas_in.system_voltage_code)
    else $error("system code mismatch");
  AST_INPUT: assert property (rd_ok && paddr == 10'h044 |-> prdata[7:0] == {meas_in.input_present_flag,
    meas_in.input_voltage_code}) else $error("input result mismatch");
  AST_ICHG_SHORT: assert property (rd_ok && paddr == 10'h048 && meas_in.battery_short |-> prdata[7:0] == 8'h00)
    else $error("short charge code not zero");
  AST_ICHG_CODE: assert property (rd_ok && paddr == 10'h048 && !meas_in.battery_short |->
    prdata[7:0] == {1'b0, meas_in.charge_current_code}) else $error("charge code mismatch");
  AST_LOOP: assert property (rd_ok && paddr == 10'h04C |-> prdata[7:0] == {meas_in.input_voltage_loop_flag,
    meas_in.input_current_loop_flag, meas_in.applied_input_current_limit}) else $error("loop status mismatch");
  AST_RO_WRITE: assert property (pready && pwrite && paddr inside {10'h038, 10'h03C, 10'h044, 10'h048, 10'h04C}
    |-> !pslverr) else $error("result write refused");
endmodule
bind cas_regs cas_regs_checker i_chk (.pclk(pclk), .presetn(presetn), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas_in(meas_in), .conv_done(conv_done));

//--- test/charger_adc_status_registers_test.sv
`timescale 1ns/1ps
module charger_adc_status_registers_test;
  typedef struct packed {
    cas_pkg::cas_meas_type f;
    logic [39:0]           e;
  } cas_row_type;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic [9:0]            paddr = 10'h0;
  logic [31:0]           pwdata = 32'h0, prdata, rd;
  logic                  pready, pslverr, irq, conv_done, er;
  cas_pkg::cas_meas_type meas_in, frame = '0;
  int                    errors = 0, n_tests = 0;
  logic [9:0]            adr [5] = '{10'h038, 10'h03C, 10'h044, 10'h048, 10'h04C};
  cas_row_type           rows [3] = '{
    {1'b1, 7'h7F, 7'h7F, 1'b1, 7'h7F, 7'h7F, 1'b0, 1'b1, 1'b0, 6'h3F, 40'hFF7FFF7FBF},
    {1'b0, 7'h01, 7'h40, 1'b0, 7'h00, 7'h55, 1'b1, 1'b0, 1'b1, 6'h01, 40'h0140000041},
    {1'b0, 7'h2A, 7'h15, 1'b1, 7'h12, 7'h01, 1'b0, 1'b1, 1'b1, 6'h20, 40'h2A159201E0}};
  always #12.5 pclk = ~pclk;
  cas_conv_model i_conv (.pclk(pclk), .go(go), .frame(frame), .meas_in(meas_in), .conv_done(conv_done));
  cas_regs i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas_in(meas_in), .conv_done(conv_done), .irq(irq));
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge, so a following call never rewrites psel in the same time step
    @(posedge pclk);
  endtask
  task automatic send(input cas_pkg::cas_meas_type f);
    frame <= f;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (10) @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(25 * 3000);
    errors++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[r]) begin
      send(rows[r].f);
      for (int i = 0; i < 5; i++) begin
        xfer(1'b1, adr[i], 32'hFFFFFFFF);
        xfer(1'b0, adr[i], 32'h0);
        chk(rd, {24'h0, rows[r].e[39-8*i -: 8]});
      end
      $display("row %0d done", r);
    end
    xfer(1'b0, 10'h040, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1);
    xfer(1'b0, 10'h039, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1);
    xfer(1'b1, 10'h080, 32'hF);
    xfer(1'b1, 10'h084, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    send({1'b1, rows[2].f[37:0]});
    chk(irq, 1);
    xfer(1'b0, 10'h080, 32'h0);
    chk(rd, 1);
    xfer(1'b1, 10'h084, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    xfer(1'b1, 10'h084, 32'h1);
    xfer(1'b1, 10'h080, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    $display("error and interrupt tests done");
    // freeze: a frozen result must not move, so no thermal event can appear
    send(rows[2].f);
    xfer(1'b1, 10'h088, 32'h1);
    xfer(1'b0, 10'h088, 32'h0);
    chk(rd, 1);
    send({1'b1, rows[2].f[37:0]});
    chk(irq, 0);
    xfer(1'b1, 10'h088, 32'h0);
    send({1'b1, rows[2].f[37:0]});
    chk(irq, 1);
    $display("freeze test done");
    // mid-run reset with the toggle line left high
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, 10'h038, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, 10'h080, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
    conclude();
  end
endmodule
